/* File: hw/dspsmp_defs.svh */
// Purpose: Constants for the scaling, multiply and status path
// Assumes: Included by bare name wherever needed
// Notes:   Field positions refer to the two 16-bit status words
`ifndef DSPSMP_DEFS_SVH
`define DSPSMP_DEFS_SVH

`define DSPSMP_ST0_ARP_MSB  15
`define DSPSMP_ST0_ARP_LSB  13
`define DSPSMP_ST0_OV       12
`define DSPSMP_ST0_OVM      11
`define DSPSMP_ST0_DP_MSB   8
`define DSPSMP_ST1_ARB_MSB  15
`define DSPSMP_ST1_ARB_LSB  13
`define DSPSMP_ST1_CNF      12
`define DSPSMP_ST1_TC       11
`define DSPSMP_ST1_SXM      10
`define DSPSMP_ST1_C        9
`define DSPSMP_ST1_PM_MSB   1

`define DSPSMP_RST_GLOBAL_INTERRUPT_MASK     1'b1
`define DSPSMP_RST_OV       1'b0
`define DSPSMP_RST_OVM      1'b0
`define DSPSMP_RST_SXM      1'b1
`define DSPSMP_RST_XF       1'b1
`define DSPSMP_RST_TC       1'b0
`define DSPSMP_RST_C        1'b1
`define DSPSMP_RST_CNF      1'b0
`define DSPSMP_RST_DP       9'h000
`define DSPSMP_RST_AUXP     3'h0
`define DSPSMP_RST_OPND     16'h0000
`define DSPSMP_RST_PROD     32'h0000_0000
`define DSPSMP_RST_ACC      32'h0000_0000

`define DSPSMP_RSVD_ST0     1'b1
`define DSPSMP_RSVD_ST1_HI  4'hf
`define DSPSMP_RSVD_ST1_LO  2'h3

`define DSPSMP_SAT_POS      32'h7fff_ffff
`define DSPSMP_SAT_NEG      32'h8000_0000
`define DSPSMP_PS_LEFT1     1
`define DSPSMP_PS_LEFT4     4
`define DSPSMP_PS_RIGHT6    6
`define DSPSMP_MAX_SHIFT    5'h10

`endif

/* File: hw/dspsmp_input_scaler.sv */
// Purpose: 16 to 32 bit input scaling shifter
// Assumes: Counts above the maximum are clamped
// Notes:   Purely combinational so it costs no cycle
`timescale 1ns/10ps
`include "dspsmp_defs.svh"
module dspsmp_input_scaler #(
    parameter int IN_W  = 16,
    parameter int OUT_W = 32
) (
    input  wire logic [IN_W-1:0]  operand,
    input  wire logic [4:0]       shiftCount,
    input  wire logic             signExtend,
    output logic      [OUT_W-1:0] scaled
);
    logic [OUT_W-1:0] extended;
    logic [4:0]       count;

    generate
        if (IN_W != 16 || OUT_W != 32) begin : g_bad
            $error("dspsmp_input_scaler serves only 16 in, 32 out");
        end
    endgenerate

    always_comb begin
        count = (shiftCount > `DSPSMP_MAX_SHIFT) ? `DSPSMP_MAX_SHIFT
                                                 : shiftCount;
        extended = signExtend ? {{(OUT_W-IN_W){operand[IN_W-1]}}, operand}
                              : {{(OUT_W-IN_W){1'b0}}, operand};
        scaled = extended << count;
    end
endmodule

/* File: hw/dspsmp_mul_if.sv */
// Purpose: Carrier between the status path and the multiplier
// Assumes: Single clock domain
// Notes:   ctrl drives requests, unit returns registers and the combinational scaled product
`timescale 1ns/10ps
interface dspsmp_mul_if;
    logic                    loadOperand;
    logic [15:0]             operandIn;
    logic                    mulStb;
    logic                    mulUnsigned;
    logic [15:0]             mulData;
    dspsmp_pkg::dspsmp_pm_t  pm;
    logic [15:0]             operandReg;
    logic [31:0]             productReg;
    logic [31:0]             scaledProduct;

    modport ctrl (
        output loadOperand, operandIn, mulStb, mulUnsigned, mulData, pm,
        input  operandReg, productReg, scaledProduct
    );
    modport unit (
        input  loadOperand, operandIn, mulStb, mulUnsigned, mulData, pm,
        output operandReg, productReg, scaledProduct
    );
endinterface

/* File: hw/dspsmp_multiplier.sv */
// Purpose: Operand register, 16x16 multiplier, product register
// Assumes: One product per clock while mulStb is high
// Notes:   The scaler works on a copy, never the stored product
`timescale 1ns/10ps
`include "dspsmp_defs.svh"
module dspsmp_multiplier #(
    parameter int OP_W = 16
) (
    input  wire logic clk,
    input  wire logic arst_n,
    dspsmp_mul_if.unit mulIf
);
    generate
        if (OP_W != 16) begin : g_bad
            $error("dspsmp_multiplier serves only 16-bit operands");
        end
    endgenerate

    function automatic logic [31:0] product_scaler(input logic [31:0] p,
                                           input dspsmp_pkg::dspsmp_pm_t m);
        case (m)
            dspsmp_pkg::DSPSMP_PM_LEFT1:  product_scaler = p << `DSPSMP_PS_LEFT1;
            dspsmp_pkg::DSPSMP_PM_LEFT4:  product_scaler = p << `DSPSMP_PS_LEFT4;
            dspsmp_pkg::DSPSMP_PM_RIGHT6:
                product_scaler = 32'($signed(p) >>> `DSPSMP_PS_RIGHT6);
            default:                      product_scaler = p;
        endcase
    endfunction

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mulIf.operandReg <= `DSPSMP_RST_OPND;
        end else if (mulIf.loadOperand) begin
            mulIf.operandReg <= mulIf.operandIn;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mulIf.productReg <= `DSPSMP_RST_PROD;
        end else if (mulIf.mulStb) begin
            if (mulIf.mulUnsigned) begin
                mulIf.productReg <= mulIf.operandReg * mulIf.mulData;
            end else begin
                mulIf.productReg <= 32'($signed(mulIf.operandReg)
                                        * $signed(mulIf.mulData));
            end
        end
    end

    assign mulIf.scaledProduct = product_scaler(mulIf.productReg, mulIf.pm);
endmodule

/* File: hw/dspsmp_pkg.sv */
// Purpose: Shared types for the scaling, multiply and status path
// Assumes: Used by full scope name only
// Notes:   Flag select is one-hot so a decode never overlaps
package dspsmp_pkg;

    typedef enum logic [1:0] {
        DSPSMP_PM_NONE   = 2'h0,
        DSPSMP_PM_LEFT1  = 2'h1,
        DSPSMP_PM_LEFT4  = 2'h2,
        DSPSMP_PM_RIGHT6 = 2'h3
    } dspsmp_pm_t;

    typedef enum logic [6:0] {
        DSPSMP_FL_GLOBAL_INTERRUPT_MASK = 7'h01,
        DSPSMP_FL_OVM  = 7'h02,
        DSPSMP_FL_SXM  = 7'h04,
        DSPSMP_FL_XF   = 7'h08,
        DSPSMP_FL_TC   = 7'h10,
        DSPSMP_FL_C    = 7'h20,
        DSPSMP_FL_CNF  = 7'h40
    } dspsmp_flag_t;

endpackage

/* File: hw/dspsmp_status_path.sv */
// Purpose: Status flags, input scaling, multiply and saturating acc
// Assumes: Decoder strobes are one-cycle and synchronous to clk
// Notes:   Flag results land on the same edge as the result
`timescale 1ns/10ps
`include "dspsmp_defs.svh"
module dspsmp_status_path #(
    parameter int DATA_W = 16,
    parameter int ACC_W  = 32
) (
    input  wire logic                      clk,
    input  wire logic                      arst_n,
    input  wire logic                      setBitStb,
    input  wire logic                      clrBitStb,
    input  wire dspsmp_pkg::dspsmp_flag_t  bitSel,
    input  wire logic                      loadStatus0Stb,
    input  wire logic                      loadStatus1Stb,
    input  wire logic [15:0]               statusLoadData,
    input  wire logic                      setProductModeStb,
    input  wire dspsmp_pkg::dspsmp_pm_t    productModeIn,
    input  wire logic                      loadPageStb,
    input  wire logic [8:0]                pageIn,
    input  wire logic [6:0]                instrLow7,
    input  wire logic                      irqTrapStb,
    input  wire logic                      maskableIrqReq,
    input  wire logic                      nmiReq,
    input  wire logic                      branchOvTestStb,
    input  wire logic                      bitTestStb,
    input  wire logic                      bitTestValue,
    input  wire logic                      auxCompareStb,
    input  wire logic                      auxCompareTrue,
    input  wire logic                      normalizeStb,
    input  wire logic [DATA_W-1:0]         busOperand,
    input  wire logic [4:0]                shiftImm,
    input  wire logic                      shiftFromOperand,
    input  wire logic                      noSignExtend,
    input  wire logic                      loadOperandStb,
    input  wire logic                      multiplyStb,
    input  wire logic                      multiplyUnsigned,
    input  wire logic                      accWriteStb,
    input  wire logic [ACC_W-1:0]          aluResult,
    input  wire logic                      aluOverflow,
    input  wire logic                      overflowNegative,
    output logic      [15:0]               directAddr,
    output logic                           maskableIrqAccept,
    output logic                           nmiAccept,
    output logic                           generalOutputPin,
    output logic      [ACC_W-1:0]          scaledOperand,
    output logic      [ACC_W-1:0]          scaledProduct,
    output logic      [ACC_W-1:0]          productReg,
    output logic      [DATA_W-1:0]         operandReg,
    output logic      [ACC_W-1:0]          accumulator,
    output logic      [15:0]               statusWord0,
    output logic      [15:0]               statusWord1
);
    logic [8:0]              dataPagePointer;
    logic                    globalInterruptMask;
    logic                    arithWrapLatch;
    logic                    saturateEnable;
    dspsmp_pkg::dspsmp_pm_t  productShiftSelect;
    logic                    signExtendMode;
    logic                    testFlag;
    logic                    generalOutputFlag;
    logic                    carryFlag;
    logic                    ramConfig;
    logic [2:0]              auxPointer;
    logic [2:0]              auxPointerBuf;
    logic [4:0]              shiftCount;
    logic                    aluWrap;

    dspsmp_mul_if mulIf ();

    generate
        if (DATA_W != 16 || ACC_W != 32) begin : g_bad
            $error("dspsmp_status_path serves only 16/32-bit widths");
        end
    endgenerate

    // Next value of a flag steered by set/clear instructions
    function automatic logic setClr(input logic cur,
                                    input dspsmp_pkg::dspsmp_flag_t f);
        if (setBitStb && bitSel == f) begin
            setClr = 1'b1;
        end else if (clrBitStb && bitSel == f) begin
            setClr = 1'b0;
        end else begin
            setClr = cur;
        end
    endfunction

    assign directAddr = {dataPagePointer, instrLow7};

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dataPagePointer <= `DSPSMP_RST_DP;
            auxPointer      <= `DSPSMP_RST_AUXP;
        end else if (loadPageStb) begin
            dataPagePointer <= pageIn;
        end else if (loadStatus0Stb) begin
            dataPagePointer <= statusLoadData[`DSPSMP_ST0_DP_MSB:0];
            auxPointer <= statusLoadData[`DSPSMP_ST0_ARP_MSB:
                                         `DSPSMP_ST0_ARP_LSB];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            globalInterruptMask <= `DSPSMP_RST_GLOBAL_INTERRUPT_MASK;
        end else if (irqTrapStb) begin
            globalInterruptMask <= 1'b1;
        end else begin
            globalInterruptMask <= setClr(globalInterruptMask,
                                          dspsmp_pkg::DSPSMP_FL_GLOBAL_INTERRUPT_MASK);
        end
    end

    assign maskableIrqAccept = maskableIrqReq && !globalInterruptMask;
    assign nmiAccept         = nmiReq;

    assign aluWrap = accWriteStb && aluOverflow;

    // sticky overflow, set wins over clear
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            arithWrapLatch <= `DSPSMP_RST_OV;
        end else if (aluWrap) begin
            arithWrapLatch <= 1'b1;
        end else if (loadStatus0Stb) begin
            arithWrapLatch <= statusLoadData[`DSPSMP_ST0_OV];
        end else if (branchOvTestStb) begin
            arithWrapLatch <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            saturateEnable <= `DSPSMP_RST_OVM;
        end else if (loadStatus0Stb) begin
            saturateEnable <= statusLoadData[`DSPSMP_ST0_OVM];
        end else begin
            saturateEnable <= setClr(saturateEnable,
                                     dspsmp_pkg::DSPSMP_FL_OVM);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            productShiftSelect <= dspsmp_pkg::DSPSMP_PM_NONE;
        end else if (setProductModeStb) begin
            productShiftSelect <= productModeIn;
        end else if (loadStatus1Stb) begin
            productShiftSelect <= dspsmp_pkg::dspsmp_pm_t'(
                statusLoadData[`DSPSMP_ST1_PM_MSB:0]);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            signExtendMode <= `DSPSMP_RST_SXM;
        end else if (loadStatus1Stb) begin
            signExtendMode <= statusLoadData[`DSPSMP_ST1_SXM];
        end else begin
            signExtendMode <= setClr(signExtendMode,
                                     dspsmp_pkg::DSPSMP_FL_SXM);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            testFlag <= `DSPSMP_RST_TC;
        end else if (bitTestStb) begin
            testFlag <= bitTestValue;
        end else if (auxCompareStb) begin
            testFlag <= auxCompareTrue;
        end else if (normalizeStb) begin
            testFlag <= accumulator[ACC_W-1] ^ accumulator[ACC_W-2];
        end else if (loadStatus1Stb) begin
            testFlag <= statusLoadData[`DSPSMP_ST1_TC];
        end else begin
            testFlag <= setClr(testFlag, dspsmp_pkg::DSPSMP_FL_TC);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            generalOutputFlag <= `DSPSMP_RST_XF;
        end else begin
            generalOutputFlag <= setClr(generalOutputFlag,
                                        dspsmp_pkg::DSPSMP_FL_XF);
        end
    end
    assign generalOutputPin = generalOutputFlag;

    // Carry and RAM map bits are held here only for save and restore
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            carryFlag     <= `DSPSMP_RST_C;
            ramConfig     <= `DSPSMP_RST_CNF;
            auxPointerBuf <= `DSPSMP_RST_AUXP;
        end else if (loadStatus1Stb) begin
            carryFlag     <= statusLoadData[`DSPSMP_ST1_C];
            ramConfig     <= statusLoadData[`DSPSMP_ST1_CNF];
            auxPointerBuf <= statusLoadData[`DSPSMP_ST1_ARB_MSB:
                                            `DSPSMP_ST1_ARB_LSB];
        end else begin
            carryFlag <= setClr(carryFlag, dspsmp_pkg::DSPSMP_FL_C);
            ramConfig <= setClr(ramConfig, dspsmp_pkg::DSPSMP_FL_CNF);
        end
    end

    // status words show flags after the result edge
    assign statusWord0 = {auxPointer, arithWrapLatch, saturateEnable,
                          `DSPSMP_RSVD_ST0, globalInterruptMask,
                          dataPagePointer};
    assign statusWord1 = {auxPointerBuf, ramConfig, testFlag,
                          signExtendMode, carryFlag, `DSPSMP_RSVD_ST1_HI,
                          generalOutputFlag, `DSPSMP_RSVD_ST1_LO,
                          productShiftSelect};

    assign shiftCount = shiftFromOperand ? {1'b0, operandReg[3:0]}
                                         : shiftImm;

    dspsmp_input_scaler #(
        .IN_W  (DATA_W),
        .OUT_W (ACC_W)
    ) u_scaler (
        .operand    (busOperand),
        .shiftCount (shiftCount),
        .signExtend (signExtendMode && !noSignExtend),
        .scaled     (scaledOperand)
    );

    assign mulIf.loadOperand = loadOperandStb;
    assign mulIf.operandIn   = busOperand;
    assign mulIf.mulStb      = multiplyStb;
    assign mulIf.mulUnsigned = multiplyUnsigned;
    assign mulIf.mulData     = busOperand;
    assign mulIf.pm          = productShiftSelect;
    assign operandReg        = mulIf.operandReg;
    assign productReg        = mulIf.productReg;
    assign scaledProduct     = mulIf.scaledProduct;

    dspsmp_multiplier #(
        .OP_W (DATA_W)
    ) u_mult (
        .clk    (clk),
        .arst_n (arst_n),
        .mulIf  (mulIf)
    );

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            accumulator <= `DSPSMP_RST_ACC;
        end else if (accWriteStb) begin
            if (aluOverflow && saturateEnable) begin
                accumulator <= overflowNegative ? `DSPSMP_SAT_NEG
                                                : `DSPSMP_SAT_POS;
            end else begin
                accumulator <= aluResult;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    page_addr_a: assert property (loadPageStb |=>
        directAddr[15:7] == $past(pageIn))
        else $error("page pointer not in address");
    irq_block_a: assert property (globalInterruptMask |->
        !maskableIrqAccept && (nmiAccept == nmiReq))
        else $error("masked interrupt accepted");
    mask_load_a: assert property ((loadStatus0Stb && !setBitStb
        && !clrBitStb && !irqTrapStb) |=> $stable(globalInterruptMask))
        else $error("status load changed mask");
    trap_mask_a: assert property (irqTrapStb |=>
        globalInterruptMask && !maskableIrqAccept)
        else $error("trap did not set mask");
    ov_sticky_a: assert property (aluWrap |=> arithWrapLatch
        ##1 (arithWrapLatch || $past(loadStatus0Stb || branchOvTestStb)))
        else $error("overflow latch lost");
    sat_value_a: assert property (aluWrap && saturateEnable
        |=> accumulator == ($past(overflowNegative) ? `DSPSMP_SAT_NEG
                                                    : `DSPSMP_SAT_POS))
        else $error("wrong saturation value");
    wrap_value_a: assert property (aluWrap && !saturateEnable
        |=> accumulator == $past(aluResult))
        else $error("wrapped result altered");
    pm_hold_a: assert property (!setProductModeStb &&
        !loadStatus1Stb |=> $stable(productShiftSelect))
        else $error("product mode changed");
    product_scaler_l4_a: assert property (productShiftSelect ==
        dspsmp_pkg::DSPSMP_PM_LEFT4 |-> scaledProduct ==
        {productReg[ACC_W-5:0], 4'h0})
        else $error("left4 product shift wrong");
    prod_keep_a: assert property (!multiplyStb |=>
        $stable(productReg))
        else $error("stored product altered");
    mul_signed_a: assert property (multiplyStb && !multiplyUnsigned
        |=> productReg == 32'($signed($past(operandReg))
                              * $signed($past(busOperand))))
        else $error("signed product wrong");
    sxm_fill_a: assert property (!signExtendMode && !shiftFromOperand
        && shiftImm == 5'h0 |-> scaledOperand[31:16] == 16'h0)
        else $error("zero fill violated");
    xf_pin_a: assert property (setBitStb && bitSel ==
        dspsmp_pkg::DSPSMP_FL_XF |=> generalOutputPin)
        else $error("output pin not set");
    tc_bit_a: assert property (bitTestStb |=>
        testFlag == $past(bitTestValue))
        else $error("test flag not from bit test");

    sat_neg_c: cover property (aluWrap && saturateEnable
        && overflowNegative);
    trap_c: cover property (irqTrapStb ##1 clrBitStb);
    mac_r6_c: cover property (multiplyStb && productShiftSelect ==
        dspsmp_pkg::DSPSMP_PM_RIGHT6);
endmodule

/* File: test/dsp_scaling_multiply_status_path_tb.sv */
// Purpose: Self-checking bench for the status, scaling and multiply path
// Assumes: One strobe per call, data carried on the operand bus
// Notes:   Flag select, page and load data all ride on busOperand
`timescale 1ns/10ps
module dsp_scaling_multiply_status_path_tb;
    localparam int SET = 0, CLR = 1, LD0 = 2, LD1 = 3, SET_PRODUCT_MODE_INSTR = 4, LOAD_PAGE_INSTR = 5;
    localparam int TRAP = 6, BOV = 7, BIT = 8, AUX = 9, NRM = 10;
    localparam int LOP = 11, MUL = 12, ACC = 13;
    logic        clk, arst_n, multiplyUnsigned, shiftFromOperand;
    logic        maskableIrqReq, nmiReq, maskableIrqAccept, nmiAccept;
    logic        generalOutputPin, aluOverflow, overflowNegative;
    logic        noSignExtend;
    logic [13:0] stb;
    logic [4:0]  shiftImm;
    logic [15:0] busOperand, directAddr, operandReg;
    logic [15:0] statusWord0, statusWord1;
    logic [31:0] scaledOperand, scaledProduct, productReg;
    logic [31:0] accumulator, aluResult;
    int          checks = 0, miscompares = 0, cycles = 0;
    logic [31:0] pexp [4] = '{32'hfffffffa, 32'hfffffff4,
                              32'hffffffa0, 32'hffffffff};

    dspsmp_status_path i_dut (
        .clk, .arst_n, .setBitStb(stb[SET]), .clrBitStb(stb[CLR]),
        .bitSel(dspsmp_pkg::dspsmp_flag_t'(busOperand[6:0])),
        .loadStatus0Stb(stb[LD0]), .loadStatus1Stb(stb[LD1]),
        .statusLoadData(busOperand), .setProductModeStb(stb[SET_PRODUCT_MODE_INSTR]),
        .productModeIn(dspsmp_pkg::dspsmp_pm_t'(busOperand[1:0])),
        .loadPageStb(stb[LOAD_PAGE_INSTR]), .pageIn(busOperand[8:0]),
        .instrLow7(busOperand[15:9]), .irqTrapStb(stb[TRAP]),
        .maskableIrqReq, .nmiReq, .branchOvTestStb(stb[BOV]),
        .bitTestStb(stb[BIT]), .bitTestValue(busOperand[0]),
        .auxCompareStb(stb[AUX]), .auxCompareTrue(busOperand[0]),
        .normalizeStb(stb[NRM]), .busOperand, .shiftImm,
        .shiftFromOperand, .noSignExtend,
        .loadOperandStb(stb[LOP]), .multiplyStb(stb[MUL]),
        .multiplyUnsigned, .accWriteStb(stb[ACC]), .aluResult,
        .aluOverflow, .overflowNegative, .directAddr, .maskableIrqAccept,
        .nmiAccept, .generalOutputPin, .scaledOperand, .scaledProduct,
        .productReg, .operandReg, .accumulator, .statusWord0,
        .statusWord1);
    dspsmp_alu_model i_alu (.accIn(accumulator), .addend(scaledOperand),
        .sum(aluResult), .ovf(aluOverflow), .neg(overflowNegative));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Whole run is about 60 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            give_verdict;
        end
    end

    task chk(input string nm, input logic [31:0] got, input logic [31:0] e);
        checks++;
        if (got !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, got);
        end
    endtask
    task pulse(input int i, input logic [15:0] d);
        @(posedge clk);
        stb[i] <= 1'b1;
        busOperand <= d;
        @(posedge clk);
        stb <= 14'h0;
        #1;
    endtask
    task scl(input logic [15:0] d, input logic [4:0] n, input logic f,
             input logic [31:0] e);
        @(posedge clk);
        busOperand <= d;
        shiftImm <= n;
        shiftFromOperand <= f;
        #1;
        chk("scaled", scaledOperand, e);
    endtask
    task give_verdict;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        arst_n = 1'b0;
        stb = 14'h0;
        busOperand = 16'h0;
        shiftImm = 5'h0;
        shiftFromOperand = 1'b0;
        noSignExtend = 1'b0;
        multiplyUnsigned = 1'b0;
        maskableIrqReq = 1'b1;
        nmiReq = 1'b1;
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        #1;
        chk("st0", statusWord0, 16'h0600);
        chk("st1", statusWord1, 16'h07fc);
        chk("irq", maskableIrqAccept, 1'b0);
        chk("nmi", nmiAccept, 1'b1);
        pulse(CLR, 16'h0001);
        chk("irq", maskableIrqAccept, 1'b1);
        pulse(LD0, 16'hffff);
        chk("st0", statusWord0, 16'hfdff);
        pulse(TRAP, 16'h0000);
        chk("irq", maskableIrqAccept, 1'b0);
        pulse(LOAD_PAGE_INSTR, 16'hb5a5);
        chk("addr", directAddr, {9'h1a5, 7'h5a});
        pulse(LD0, 16'h0000);
        chk("st0", statusWord0, 16'h0600);
        pulse(LOP, 16'hfffe);
        chk("opnd", operandReg, 16'hfffe);
        @(posedge clk) multiplyUnsigned <= 1'b1;
        pulse(MUL, 16'h0003);
        chk("prod", productReg, 32'h0002fffa);
        @(posedge clk) multiplyUnsigned <= 1'b0;
        pulse(MUL, 16'h0003);
        chk("prod", productReg, 32'hfffffffa);
        for (int m = 0; m < 4; m++) begin
            pulse(SET_PRODUCT_MODE_INSTR, 16'(m));
            chk("pscl", scaledProduct, pexp[m]);
            chk("prod", productReg, 32'hfffffffa);
        end
        pulse(LD1, 16'h0000);
        chk("st1", statusWord1, 16'h01fc);
        scl(16'h8001, 5'h04, 1'b0, 32'h00080010);
        pulse(SET, 16'h0004);
        scl(16'h8001, 5'h04, 1'b0, 32'hfff80010);
        @(posedge clk) noSignExtend <= 1'b1;
        scl(16'h8001, 5'h04, 1'b0, 32'h00080010);
        @(posedge clk) noSignExtend <= 1'b0;
        scl(16'h0001, 5'h00, 1'b1, 32'h00004000);
        scl(16'h7fff, 5'h10, 1'b0, 32'h7fff0000);
        pulse(ACC, 16'h7fff);
        pulse(ACC, 16'h7fff);
        chk("acc", accumulator, 32'hfffe0000);
        chk("ov", statusWord0[12], 1'b1);
        pulse(BOV, 16'h7fff);
        chk("ov", statusWord0[12], 1'b0);
        pulse(SET, 16'h0002);
        pulse(ACC, 16'h8000);
        chk("acc", accumulator, 32'h80000000);
        chk("ov", statusWord0[12], 1'b1);
        pulse(BIT, 16'h0001);
        chk("tc", statusWord1[11], 1'b1);
        pulse(AUX, 16'h0000);
        chk("tc", statusWord1[11], 1'b0);
        pulse(NRM, 16'h0000);
        chk("tc", statusWord1[11], 1'b1);
        pulse(CLR, 16'h0008);
        chk("pin", generalOutputPin, 1'b0);
        give_verdict;
    end
endmodule

/* File: test/dspsmp_alu_model.sv */
// Purpose: Far-side adder feeding the accumulator write port
// Assumes: Two's-complement add of accumulator and scaled operand
// Notes:   Overflow direction follows the accumulator sign
`timescale 1ns/10ps
module dspsmp_alu_model (
    input  wire logic [31:0] accIn,
    input  wire logic [31:0] addend,
    output logic      [31:0] sum,
    output logic             ovf,
    output logic             neg
);
    assign sum = accIn + addend;
    // Like signs that flip mean overflow
    assign ovf = (accIn[31] == addend[31]) && (sum[31] != accIn[31]);
    assign neg = accIn[31];
endmodule
